// File: rtl/apsp_params.svh
`ifndef APSP_PARAMS_SVH
`define APSP_PARAMS_SVH

// Strap enable bit position in the feature configuration byte
`define APSP_STRAP_BIT          4
// Standby memory gate control bit of the power-management function register
`define APSP_PM_FUNC_REG        8'he4
`define APSP_MEMGATE_BIT        4
// Reset values
`define APSP_MEMGATE_EN_RST     1'b0
`define APSP_SUPPLY_PG_EN_RST   1'b1
// Debounce time in ms, clock period in ps
`define APSP_DEBOUNCE_MS        32
`define APSP_CLK_PERIOD_PS      5000
`define APSP_DEBOUNCE_CYCLES    ((`APSP_DEBOUNCE_MS * 64'd1000000000 + \
                                  `APSP_CLK_PERIOD_PS - 1) / `APSP_CLK_PERIOD_PS)

`endif

// File: rtl/apsp_pkg.sv
package apsp_pkg;

    typedef enum logic [2:0] {
        APSP_ST_STRAP = 3'h1,
        APSP_ST_RUN   = 3'h2,
        APSP_ST_OFF   = 3'h4
    } apsp_mode_t;

endpackage : apsp_pkg

// File: rtl/apsp_debounce.sv
`timescale 1ns/1ps
`include "apsp_params.svh"

module apsp_debounce #(
    parameter int unsigned CYCLES = 32'(`APSP_DEBOUNCE_CYCLES)
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic raw_in,
    output logic      clean_out
);

    typedef struct packed {
        logic        level;
        logic [31:0] count;
    } apsp_db_state_t;

    apsp_db_state_t st_reg;
    apsp_db_state_t st_next;

    always_comb
    begin
        st_next = st_reg;
        if (raw_in == st_reg.level)
            st_next.count = 32'h0;
        else if (st_reg.count >= CYCLES - 32'd1)
        begin
            st_next.level = raw_in;
            st_next.count = 32'h0;
        end
        else
            st_next.count = st_reg.count + 32'd1;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            st_reg <= '{level: 1'b1, count: 32'h0};
        else
            st_reg <= st_next;
    end

    assign clean_out = st_reg.level;

    // Level may only move after a full stable run
    level_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE_02
        $changed(st_reg.level) |-> $past(st_reg.count) == CYCLES - 32'd1)
        else $error("debounced level changed early");

endmodule : apsp_debounce

// File: rtl/apsp_seq.sv
`timescale 1ns/1ps
`include "apsp_params.svh"

// Overview of operation
// RULE_01: During standby reset, pull strap low and latch it as feature enable bit 4.
// RULE_02: Reset button change is accepted only after 32 ms stable.
// RULE_03: Memory gate routes standby power to memory in S3 when control bit set.
// RULE_04: Memory gate control starts disabled after reset.
// RULE_05: Second power-good asserts open-drain once main supply is present.
// RULE_06: Supply power-good input feeds both power-good outputs; enabled by default.
// RULE_07: Chipset drives the S5 sleep indication on the shared sleep pin.
// RULE_08: Shared pin A selects general I/O or open-drain watchdog output.
// RULE_09: Shared pin B selects general I/O or suspend LED output.
// RULE_10: With strap clear, pins stay general I/O and sequencing outputs idle; here pins A and B still follow sel_watchdog and sel_suspend_led.
module apsp_seq #(
    parameter int unsigned DEBOUNCE_CYCLES = 32'(`APSP_DEBOUNCE_CYCLES)
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic standby_resume_reset,
    input  wire logic pm_feature_strap_in,
    output logic      pm_feature_strap_pull_oe,
    output logic      pm_feature_strap,
    input  wire logic memgate_ctrl_wr,
    input  wire logic memgate_ctrl_data,
    input  wire logic supply_pg_en_wr,
    input  wire logic supply_pg_en_data,
    input  wire logic s3_sleep_in_n,
    input  wire logic s5_sleep_in_n,
    input  wire logic main_supply_present,
    input  wire logic supply_power_good_in,
    input  wire logic front_panel_reset_in_n,
    output logic      front_panel_reset_clean_n,
    output logic      standby_mem_gate_n,
    output logic      power_good_out_oe,
    output logic      second_power_good_out_oe,
    input  wire logic sel_watchdog,
    input  wire logic watchdog_timeout_n,
    input  wire logic gio_a_out,
    input  wire logic gio_a_oe,
    output logic      shared_general_io_a_oe,
    input  wire logic sel_suspend_led,
    input  wire logic suspend_led_on,
    input  wire logic gio_b_out,
    input  wire logic gio_b_oe,
    output logic      shared_general_io_b_out,
    output logic      shared_general_io_b_oe,
    output logic      s5_sleep_active
);

    typedef struct packed {
        apsp_pkg::apsp_mode_t mode;
        logic                 strap;
        logic                 memgate_en;
        logic                 pg_en;
        logic                 strap_pull;
        logic                 memgate_n;
        logic                 pg_oe;
        logic                 pg2_oe;
        logic                 fpr_n;
        logic                 io_a_oe;
        logic                 io_b_out;
        logic                 io_b_oe;
        logic                 s5_act;
    } apsp_state_t;

    apsp_state_t st_reg;
    apsp_state_t st_next;
    logic        fpr_clean;
    logic        pg_good;

    apsp_debounce #(
        .CYCLES (DEBOUNCE_CYCLES)
    ) u_fpr_db (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .raw_in    (front_panel_reset_in_n),
        .clean_out (fpr_clean)
    );

    // Supply good is only trusted while the input function is enabled
    assign pg_good = st_reg.pg_en ? supply_power_good_in : 1'b1; // see RULE_06

    always_comb
    begin
        st_next = st_reg;
        unique case (st_reg.mode)
            apsp_pkg::APSP_ST_STRAP:
            begin
                st_next.strap_pull = 1'b1; // see RULE_01
                st_next.strap      = pm_feature_strap_in; // see RULE_01
                if (!standby_resume_reset)
                    st_next.mode = pm_feature_strap_in ? apsp_pkg::APSP_ST_RUN
                                                       : apsp_pkg::APSP_ST_OFF;
            end
            apsp_pkg::APSP_ST_RUN,
            apsp_pkg::APSP_ST_OFF:
            begin
                // Pull must stand from the first STRAP cycle, one cycle after standby reset rises
                st_next.strap_pull = standby_resume_reset; // see RULE_01
                if (standby_resume_reset)
                    st_next.mode = apsp_pkg::APSP_ST_STRAP;
            end
            default: st_next.mode = apsp_pkg::APSP_ST_STRAP;
        endcase
        if (memgate_ctrl_wr)
            st_next.memgate_en = memgate_ctrl_data; // see RULE_03
        if (supply_pg_en_wr)
            st_next.pg_en = supply_pg_en_data;
        if (standby_resume_reset)
        begin
            st_next.memgate_en = `APSP_MEMGATE_EN_RST; // see RULE_04
            st_next.pg_en      = `APSP_SUPPLY_PG_EN_RST; // see RULE_06
        end
        // Sequencing outputs idle unless the strap enabled the feature set
        if (st_reg.mode == apsp_pkg::APSP_ST_RUN)
        begin
            st_next.memgate_n = !(st_reg.memgate_en && !s3_sleep_in_n); // see RULE_03
            st_next.pg_oe     = !(main_supply_present && pg_good); // see RULE_06
            st_next.pg2_oe    = !(main_supply_present && pg_good); // see RULE_05
            st_next.fpr_n     = fpr_clean; // see RULE_02
            st_next.s5_act    = !s5_sleep_in_n; // see RULE_07
        end
        else
        begin
            st_next.memgate_n = 1'b1; // see RULE_10
            st_next.pg_oe     = 1'b1;
            st_next.pg2_oe    = 1'b1;
            st_next.fpr_n     = 1'b1;
            st_next.s5_act    = 1'b0;
        end
        // Pin A open-drain: only ever pulls low; pin B drives both out and oe
        st_next.io_a_oe = sel_watchdog ? !watchdog_timeout_n // see RULE_08
                                       : (gio_a_oe && !gio_a_out);
        st_next.io_b_out = sel_suspend_led ? suspend_led_on : gio_b_out; // see RULE_09
        st_next.io_b_oe  = sel_suspend_led ? 1'b1 : gio_b_oe; // see RULE_09
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            st_reg <= '{mode: apsp_pkg::APSP_ST_STRAP, strap: 1'b0,
                        memgate_en: `APSP_MEMGATE_EN_RST, pg_en: `APSP_SUPPLY_PG_EN_RST,
                        strap_pull: 1'b1, memgate_n: 1'b1, pg_oe: 1'b1, pg2_oe: 1'b1,
                        fpr_n: 1'b1, io_a_oe: 1'b0, io_b_out: 1'b0, io_b_oe: 1'b0,
                        s5_act: 1'b0};
        else
            st_reg <= st_next;
    end

    assign pm_feature_strap_pull_oe  = st_reg.strap_pull;
    assign pm_feature_strap          = st_reg.strap;
    assign front_panel_reset_clean_n = st_reg.fpr_n;
    assign standby_mem_gate_n        = st_reg.memgate_n;
    assign power_good_out_oe         = st_reg.pg_oe;
    assign second_power_good_out_oe  = st_reg.pg2_oe;
    assign shared_general_io_a_oe    = st_reg.io_a_oe;
    assign shared_general_io_b_out   = st_reg.io_b_out;
    assign shared_general_io_b_oe    = st_reg.io_b_oe;
    assign s5_sleep_active           = st_reg.s5_act;

    strap_latch_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE_01
        (st_reg.mode == apsp_pkg::APSP_ST_STRAP) |=> pm_feature_strap == $past(pm_feature_strap_in))
        else $error("strap not captured during standby reset");

    strap_pull_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE_01
        standby_resume_reset |=> pm_feature_strap_pull_oe)
        else $error("strap pull missing in standby reset");

    memgate_s3_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE_03
        (st_reg.mode == apsp_pkg::APSP_ST_RUN && st_reg.memgate_en && !s3_sleep_in_n)
        |=> !standby_mem_gate_n)
        else $error("memory gate not driven in S3");

    memgate_rst_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE_04
        standby_resume_reset |=> !st_reg.memgate_en)
        else $error("memory gate control not cleared");

    pg2_on_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE_05
        (st_reg.mode == apsp_pkg::APSP_ST_RUN && main_supply_present && pg_good)
        |=> !second_power_good_out_oe)
        else $error("second power good not released");

    pg_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE_06
        (st_reg.pg_en && !supply_power_good_in) |=> power_good_out_oe && second_power_good_out_oe)
        else $error("power good ignores supply input");

    wdt_pin_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE_08
        (sel_watchdog && !watchdog_timeout_n) |=> shared_general_io_a_oe)
        else $error("watchdog output not driven");

    led_pin_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE_09
        sel_suspend_led |=> shared_general_io_b_oe && shared_general_io_b_out == $past(suspend_led_on))
        else $error("suspend led not routed");

    strap_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE_10
        (st_reg.mode == apsp_pkg::APSP_ST_OFF) |=> standby_mem_gate_n && !s5_sleep_active)
        else $error("outputs active with strap clear");

endmodule : apsp_seq

// File: verif/apsp_partner.sv
`timescale 1ns/1ps

module apsp_partner #(
    parameter int PG_DELAY = 4
) (
    input  wire logic clk_sys,
    input  wire logic sleep_s3,
    input  wire logic sleep_s5,
    input  wire logic supply_on,
    input  wire logic pg_ok,
    input  wire logic press,
    output logic      s3_sleep_in_n,
    output logic      s5_sleep_in_n,
    output logic      main_supply_present,
    output logic      supply_power_good_in,
    output logic      front_panel_reset_in_n
);
    int   pg_cnt = 0;
    int   bounce = 0;
    logic press_q = 1'b0;

    initial
    begin
        {s3_sleep_in_n, s5_sleep_in_n, front_panel_reset_in_n} = 3'h7;
        {main_supply_present, supply_power_good_in} = 2'h0;
    end

    always @(posedge clk_sys)
    begin
        s3_sleep_in_n <= ~sleep_s3;
        s5_sleep_in_n <= ~sleep_s5;
        main_supply_present <= supply_on;
        pg_cnt <= supply_on ? pg_cnt + 1 : 0;
        // Supply good lags the rail, and may be held bad on command
        supply_power_good_in <= supply_on && pg_ok && pg_cnt >= PG_DELAY;
        // Contacts chatter for a few cycles on every change
        press_q <= press;
        if (press != press_q)
            bounce <= 5;
        else if (bounce > 0)
            bounce <= bounce - 1;
        front_panel_reset_in_n <= (bounce > 1) ? ~front_panel_reset_in_n : ~press;
    end
endmodule : apsp_partner

// File: verif/apsp_seq_tb.sv
`timescale 1ns/1ps

module apsp_seq_tb;
    localparam int DB = 16;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        srr = 1'b1, strap_in = 1'b1, mg_wr = 1'b0, mg_d = 1'b0, pg_wr = 1'b0;
    logic        pg_d = 1'b0, s3 = 1'b0, s5 = 1'b0, sup = 1'b0, pg_ok = 1'b1, press = 1'b0;
    logic        sel_a = 1'b0, wdt_n = 1'b1, a_oe = 1'b0, sel_b = 1'b0, led = 1'b0;
    logic        b_out = 1'b0, b_oe = 1'b0, s3_n, s5_n, present, pg_in, btn_n;
    logic        pull_oe, strap, clean_n, mg_n, pg_oe, pg2_oe, io_a_oe, io_b_out, io_b_oe;
    logic        s5_act, a_out = 1'b0;
    logic [31:0] lfsr = 32'h8273b743;
    int          err_total = 0;
    int          n_tests = 0;
    int          mem_en = 0, pg_en = 1, cyc;

    always #2.5 clk_sys = ~clk_sys;

    apsp_partner far (.clk_sys(clk_sys), .sleep_s3(s3), .sleep_s5(s5), .supply_on(sup),
        .pg_ok(pg_ok), .press(press), .s3_sleep_in_n(s3_n), .s5_sleep_in_n(s5_n),
        .main_supply_present(present), .supply_power_good_in(pg_in),
        .front_panel_reset_in_n(btn_n));

    apsp_seq #(.DEBOUNCE_CYCLES(DB)) DUT (.clk_sys(clk_sys), .rst_n(rst_n),
        .standby_resume_reset(srr), .pm_feature_strap_in(strap_in),
        .pm_feature_strap_pull_oe(pull_oe), .pm_feature_strap(strap),
        .memgate_ctrl_wr(mg_wr), .memgate_ctrl_data(mg_d), .supply_pg_en_wr(pg_wr),
        .supply_pg_en_data(pg_d), .s3_sleep_in_n(s3_n), .s5_sleep_in_n(s5_n),
        .main_supply_present(present), .supply_power_good_in(pg_in),
        .front_panel_reset_in_n(btn_n), .front_panel_reset_clean_n(clean_n),
        .standby_mem_gate_n(mg_n), .power_good_out_oe(pg_oe),
        .second_power_good_out_oe(pg2_oe), .sel_watchdog(sel_a), .watchdog_timeout_n(wdt_n),
        .gio_a_out(a_out), .gio_a_oe(a_oe), .shared_general_io_a_oe(io_a_oe),
        .sel_suspend_led(sel_b), .suspend_led_on(led), .gio_b_out(b_out), .gio_b_oe(b_oe),
        .shared_general_io_b_out(io_b_out), .shared_general_io_b_oe(io_b_oe),
        .s5_sleep_active(s5_act));

    function automatic logic [31:0] lfsr_next(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next

    task automatic tick(int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    task automatic chk(string nm, logic e, logic s);
        n_tests++;
        if (s !== e)
        begin
            err_total++;
            $display("mismatch %s expected %b seen %b", nm, e, s);
        end
    endtask : chk

    task automatic chk_seq(logic on);
        logic good;
        good = on && sup && (pg_ok || pg_en == 0);
        chk("power_good_out_oe", !good, pg_oe);
        chk("second_power_good_out_oe", !good, pg2_oe);
        chk("standby_mem_gate_n", !(on && mem_en == 1 && s3), mg_n);
        chk("s5_sleep_active", on && s5, s5_act);
    endtask : chk_seq

    task automatic strap_window(logic v);
        srr <= 1'b1;
        strap_in <= v;
        tick(3);
        chk("pm_feature_strap_pull_oe", 1'b1, pull_oe);
        srr <= 1'b0;
        tick(3);
        chk("pm_feature_strap_pull_oe", 1'b0, pull_oe);
        chk("pm_feature_strap", v, strap);
        mem_en = 0;
        pg_en = 1;
    endtask : strap_window

    task automatic wait_clean(logic v);
        cyc = 0;
        while (clean_n !== v && cyc < 4 * DB)
        begin
            tick(1);
            cyc++;
        end
        chk("front_panel_reset_clean_n", v, clean_n);
        chk("debounce_delay", 1'b1, cyc >= DB);
        if (clean_n !== v)
            report_and_stop;
    endtask : wait_clean

    initial
    begin
        tick(2);
        rst_n <= 1'b1;
        strap_window(1'b1);
        for (int i = 0; i < 32; i++)
        begin
            lfsr = lfsr_next(lfsr);
            {sup, pg_ok, s3, s5, sel_a, wdt_n, a_oe} <= lfsr[6:0];
            {sel_b, led, b_out, b_oe, mg_d, pg_d, a_out} <= lfsr[13:7];
            // First rounds write nothing so the defaults show
            mg_wr <= (i >= 4);
            pg_wr <= (i >= 4);
            tick(1);
            mg_wr <= 1'b0;
            pg_wr <= 1'b0;
            if (i >= 4)
            begin
                mem_en = mg_d;
                pg_en = pg_d;
            end
            tick(8);
            chk_seq(1'b1);
            chk("shared_general_io_a_oe", sel_a ? !wdt_n : (a_oe && !a_out), io_a_oe);
            chk("shared_general_io_b_out", sel_b ? led : b_out, io_b_out);
            chk("shared_general_io_b_oe", sel_b ? 1'b1 : b_oe, io_b_oe);
        end
        press <= 1'b1;
        tick(DB / 2);
        press <= 1'b0;
        tick(2 * DB);
        chk("front_panel_reset_clean_n", 1'b1, clean_n);
        press <= 1'b1;
        wait_clean(1'b0);
        press <= 1'b0;
        wait_clean(1'b1);
        strap_window(1'b0);
        {sup, pg_ok, s3, s5, press} <= 5'h1f;
        tick(3 * DB);
        chk_seq(1'b0);
        chk("front_panel_reset_clean_n", 1'b1, clean_n);
        press <= 1'b0;
        strap_window(1'b1);
        tick(8);
        chk_seq(1'b1);
        report_and_stop;
    end
endmodule : apsp_seq_tb
